// ### common/risx_pkg.sv
// Shared constants, types and register map of the instruction execute block
package risx_pkg;
   localparam int XLEN = 32;
   localparam int MLEN = 64;
   // Instruction fields (bit 0 is the most significant bit of the word)
   localparam logic [5:0] OPC_X     = 6'h1F;
   localparam logic [9:0] XO_RRIB   = 10'h219;
   localparam logic [5:0] OPC_CALL  = 6'h11;
   localparam logic [5:0] OPC_SUBI  = 6'h0C;
   // Wishbone register byte addresses
   localparam logic [7:0] A_INSN    = 8'h00;
   localparam logic [7:0] A_CTRL    = 8'h04;
   localparam logic [7:0] A_STAT    = 8'h08;
   localparam logic [7:0] A_MASK    = 8'h0C;
   localparam logic [7:0] A_GPR0    = 8'h40;
   localparam logic [7:0] A_GPR_END = 8'hBC;
   localparam logic [7:0] A_CR0     = 8'hC0;
   localparam logic [7:0] A_XER     = 8'hC4;
   localparam logic [7:0] A_SAV0    = 8'hC8;
   localparam logic [7:0] A_SAV1    = 8'hCC;
   localparam logic [7:0] A_LR      = 8'hD0;
   localparam logic [7:0] A_CTR_HI  = 8'hD4;
   localparam logic [7:0] A_CTR_LO  = 8'hD8;
   localparam logic [7:0] A_MST_HI  = 8'hDC;
   localparam logic [7:0] A_MST_LO  = 8'hE0;
   localparam logic [7:0] A_CIA     = 8'hE4;
   // Event bit positions
   localparam int EV_DONE = 0;
   localparam int EV_CALL = 1;
   localparam int EV_ILL  = 2;
   localparam int NEV     = 3;
   // Condition field bits (3=below,2=above,1=zero,0=sticky overflow)
   localparam int CR_NEG = 3;
   localparam int CR_POS = 2;
   localparam int CR_ZER = 1;
   localparam int CR_SO = 0;
   // Exception register: sticky ovf at 0, ovf at 1, carry at 2 (our layout)
   localparam int XER_SO = 0;
   localparam int XER_CA = 2;
   // save_restore_1 copy mask: bits 0,5-9,16-31 (big-endian) -> little-endian
   localparam logic [31:0] SAV1_KEEP = 32'h87C0FFFF;
   // count copy mask: bits 0-32,37-41,48-63 (big-endian)
   localparam logic [63:0] CTR_KEEP  = 64'hFFFFFFFF87C0FFFF;
   localparam logic [31:0] INSN_STEP = 32'h00000004;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_READ = 4'b0010,
      ST_EXEC = 4'b0100,
      ST_WB   = 4'b1000
   } risx_st_e;
endpackage

// ### common/risx_gpr_if.sv
// Register file access group between the executor and its register memory
`timescale 1ns/1ps
`default_nettype none
interface risx_gpr_if;
   logic [4:0]  ra_a;
   logic [4:0]  ra_b;
   logic [4:0]  ra_c;
   logic [31:0] rd_a;
   logic [31:0] rd_b;
   logic [31:0] rd_c;
   logic        we;
   logic [4:0]  wa;
   logic [31:0] wd;
   modport ctl (output ra_a, ra_b, ra_c, we, wa, wd, input rd_a, rd_b, rd_c);
   modport mem (input ra_a, ra_b, ra_c, we, wa, wd, output rd_a, rd_b, rd_c);
endinterface
`default_nettype wire

// ### hw/risx_gpr_mem.sv
// General-purpose register memory, three registered read ports, one write port
`timescale 1ns/1ps
`default_nettype none
module risx_gpr_mem #(
   parameter int N = 32
) (
   input  wire logic clk_i,
   risx_gpr_if.mem   g
);
   logic [31:0] mem [N];
   always_ff @(posedge clk_i) begin
      if (g.we) begin
         mem[g.wa] <= g.wd;
      end
      // Write-through so a read in the write's cycle sees the new word
      g.rd_a <= (g.we && g.wa == g.ra_a) ? g.wd : mem[g.ra_a];
      g.rd_b <= (g.we && g.wa == g.ra_b) ? g.wd : mem[g.ra_b];
      g.rd_c <= (g.we && g.wa == g.ra_c) ? g.wd : mem[g.ra_c];
   end
endmodule
`default_nettype wire

// ### hw/risx_irq.sv
// Sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module risx_irq #(
   parameter int N = 3
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [N-1:0] ev_i,
   input  wire logic         clr_we_i,
   input  wire logic [N-1:0] clr_i,
   input  wire logic         mask_we_i,
   input  wire logic [N-1:0] mask_i,
   output logic      [N-1:0] stat_o,
   output logic      [N-1:0] mask_o,
   output logic              irq_o
);
   typedef struct packed {
      logic [N-1:0] stat;
      logic [N-1:0] mask;
      logic         irq;
   } risx_irq_s;
   risx_irq_s s_r, s_nxt;
   always_comb begin
      s_nxt = s_r;
      // A set in the same cycle as a clear wins
      s_nxt.stat = (s_r.stat & ~(clr_we_i ? clr_i : '0)) | ev_i;
      if (mask_we_i) begin
         s_nxt.mask = mask_i;
      end
      s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign stat_o = s_r.stat;
   assign mask_o = s_r.mask;
   assign irq_o  = s_r.irq;
endmodule
`default_nettype wire

// ### hw/risx_exec.sv
// Instruction executor: rotate-insert-bit, system calls, subtract immediate
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: Insert source bit 0 at count position
// RULE2: Decode primary 31, extended 537, record bit
// RULE3: Rotate-insert never touches exception register
// RULE4: Record bit updates condition field zero
// RULE5: Other destination bits keep old value
// RULE6: System call interrupts, next address saved
// RULE7: Copy state bits 0,5-9,16-31 to save_restore_1
// RULE8: Save_restore_1 bits 1-4,10-15 unchecked
// RULE9: Omitted call tier encodes as zero
// RULE10: System calls leave machine state unchanged
// RULE11: Decode primary 17, bit 30 set
// RULE12: Vectored: primary 17, bit30 0, bit31 1
// RULE13: Vectored call saves next address in link
// RULE14: Copy state bits 0-32,37-41,48-63 to count
// RULE15: Count bits 33-36,42-47 unchecked
// RULE16: Subtract signed immediate into destination
// RULE17: Primary 12, executes as add immediate carrying
// RULE18: Subtract sets carry, keeps condition field
module risx_exec #(
   parameter int NGPR = 32
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             err_o,
   output logic             busy_o,
   output logic             irq_o
);
   // ----------------------------------------------------------------
   // State, register memory and instruction fields
   // ----------------------------------------------------------------
   typedef struct packed {
      risx_pkg::risx_st_e st;
      logic [31:0]        insn;
      logic [31:0]        cia;
      logic [31:0]        lr;
      logic [31:0]        sav0;
      logic [31:0]        sav1;
      logic [63:0]        ctr;
      logic [63:0]        mst;
      logic [3:0]         cr0;
      logic [2:0]         xer;
      logic               gwe;
      logic [4:0]         gwa;
      logic [31:0]        gwd;
      logic [31:0]        dat;
      logic               ack;
      logic               err;
      logic               busy;
      logic [risx_pkg::NEV-1:0] ev;
   } risx_exec_s;

   risx_exec_s s_r, s_nxt;
   risx_gpr_if g ();
   logic [risx_pkg::NEV-1:0] stat_w;
   logic [risx_pkg::NEV-1:0] mask_w;
   logic                     irq_w;

   risx_gpr_mem #(.N(NGPR)) u_mem (
      .clk_i (clk_i),
      .g     (g)
   );

   // Big-endian bit k of the word is little-endian bit 31-k
   logic [5:0]  f_opc;
   logic [4:0]  f_tgt;
   logic [4:0]  f_sra;
   logic [4:0]  f_cnt;
   logic [9:0]  f_xo;
   logic        f_rec;
   logic        f_b30;
   logic [15:0] f_imm;
   assign f_opc = s_r.insn[31:26];
   assign f_tgt = s_r.insn[25:21];
   assign f_sra = s_r.insn[20:16];
   assign f_cnt = s_r.insn[15:11];
   assign f_xo  = s_r.insn[10:1];
   assign f_rec = s_r.insn[0];
   assign f_b30 = s_r.insn[1];
   assign f_imm = s_r.insn[15:0];

   logic is_rrib;
   logic is_call;
   logic is_scv;
   logic is_subi;
   assign is_rrib = (f_opc == risx_pkg::OPC_X) && (f_xo == risx_pkg::XO_RRIB); // RULE2
   assign is_call = (f_opc == risx_pkg::OPC_CALL) && f_b30;                   // RULE11
   assign is_scv  = (f_opc == risx_pkg::OPC_CALL) && !f_b30 && f_rec;         // RULE12
   assign is_subi = (f_opc == risx_pkg::OPC_SUBI);                            // RULE17

   // ----------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------
   logic [31:0] ins_val;
   logic [4:0]  ins_pos;
   logic [32:0] sum;
   logic [31:0] nia;
   always_comb begin
      // Source at port a, count at port b, old destination at port c
      ins_pos = g.rd_b[4:0];                        // RULE1
      ins_val = g.rd_c;                             // RULE5
      ins_val[5'd31 - ins_pos] = g.rd_a[31];        // RULE1
      // Immediate already negated by the assembler: plain add
      sum = {1'b0, g.rd_c} + {1'b0, {{16{f_imm[15]}}, f_imm}}; // RULE16 RULE17
      nia = s_r.cia + risx_pkg::INSN_STEP;
   end

   function automatic logic [3:0] cr_of(input logic [31:0] v, input logic so);
      cr_of = {v[31], !v[31] && (v != 32'h00000000), v == 32'h00000000, so};
   endfunction

   // ----------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   logic        hit;
   always_comb begin
      hit    = 1'b1;
      rd_mux = 32'h00000000;
      case (adr_i)
         risx_pkg::A_INSN:   rd_mux = s_r.insn;
         risx_pkg::A_CTRL:   rd_mux = {31'h0, s_r.busy};
         risx_pkg::A_STAT:   rd_mux = {29'h0, stat_w};
         risx_pkg::A_MASK:   rd_mux = {29'h0, mask_w};
         risx_pkg::A_CR0:    rd_mux = {28'h0, s_r.cr0};
         risx_pkg::A_XER:    rd_mux = {29'h0, s_r.xer};
         risx_pkg::A_SAV0:   rd_mux = s_r.sav0;
         risx_pkg::A_SAV1:   rd_mux = s_r.sav1;
         risx_pkg::A_LR:     rd_mux = s_r.lr;
         risx_pkg::A_CTR_HI: rd_mux = s_r.ctr[63:32];
         risx_pkg::A_CTR_LO: rd_mux = s_r.ctr[31:0];
         risx_pkg::A_MST_HI: rd_mux = s_r.mst[63:32];
         risx_pkg::A_MST_LO: rd_mux = s_r.mst[31:0];
         risx_pkg::A_CIA:    rd_mux = s_r.cia;
         default: begin
            if (adr_i >= risx_pkg::A_GPR0 && adr_i <= risx_pkg::A_GPR_END && adr_i[1:0] == 2'b00) begin
               rd_mux = g.rd_a;
            end else begin
               hit = 1'b0;
            end
         end
      endcase
   end

   logic req;
   logic is_gpr;
   logic [4:0] gidx;
   assign req    = cyc_i && stb_i && !s_r.ack && !s_r.err;
   assign is_gpr = adr_i >= risx_pkg::A_GPR0 && adr_i <= risx_pkg::A_GPR_END;
   assign gidx   = 5'(adr_i[7:2] - risx_pkg::A_GPR0[7:2]);

   // ----------------------------------------------------------------
   // Control
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt     = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.err = 1'b0;
      s_nxt.gwe = 1'b0;
      s_nxt.ev  = '0;
      g.ra_a = is_gpr && req && s_r.st == risx_pkg::ST_IDLE ? gidx : f_tgt;
      g.ra_b = f_cnt;
      g.ra_c = f_sra;
      g.we   = s_r.gwe;
      g.wa   = s_r.gwa;
      g.wd   = s_r.gwd;
      case (s_r.st)
         risx_pkg::ST_IDLE: begin
            if (req) begin
               if (we_i && sel_i == 4'hF) begin
                  s_nxt.ack = 1'b1;
                  case (adr_i)
                     risx_pkg::A_INSN: begin
                        s_nxt.insn = dat_i;
                        s_nxt.busy = 1'b1;
                        s_nxt.st   = risx_pkg::ST_READ;
                     end
                     risx_pkg::A_CR0:    s_nxt.cr0 = dat_i[3:0];
                     risx_pkg::A_XER:    s_nxt.xer = dat_i[2:0];
                     risx_pkg::A_SAV0:   s_nxt.sav0 = dat_i;
                     risx_pkg::A_SAV1:   s_nxt.sav1 = dat_i;
                     risx_pkg::A_LR:     s_nxt.lr = dat_i;
                     risx_pkg::A_CTR_HI: s_nxt.ctr[63:32] = dat_i;
                     risx_pkg::A_CTR_LO: s_nxt.ctr[31:0] = dat_i;
                     risx_pkg::A_MST_HI: s_nxt.mst[63:32] = dat_i;
                     risx_pkg::A_MST_LO: s_nxt.mst[31:0] = dat_i;
                     risx_pkg::A_CIA:    s_nxt.cia = dat_i;
                     risx_pkg::A_STAT, risx_pkg::A_MASK: ;
                     default: begin
                        if (is_gpr && adr_i[1:0] == 2'b00) begin
                           s_nxt.gwe = 1'b1;
                           s_nxt.gwa = gidx;
                           s_nxt.gwd = dat_i;
                        end else begin
                           s_nxt.ack = 1'b0;
                           s_nxt.err = 1'b1;
                        end
                     end
                  endcase
               end else if (we_i) begin
                  s_nxt.err = 1'b1;
               end else if (is_gpr && hit) begin
                  // Memory read data arrive one cycle later
                  s_nxt.st    = risx_pkg::ST_WB;
               end else begin
                  s_nxt.ack = hit;
                  s_nxt.err = !hit;
                  s_nxt.dat = rd_mux;
               end
            end
         end
         risx_pkg::ST_READ: begin
            s_nxt.st = risx_pkg::ST_EXEC;
         end
         risx_pkg::ST_EXEC: begin
            s_nxt.st    = risx_pkg::ST_IDLE;
            s_nxt.busy  = 1'b0;
            s_nxt.cia   = nia;
            s_nxt.ev[risx_pkg::EV_DONE] = 1'b1;
            if (is_rrib) begin
               s_nxt.gwe = 1'b1;
               s_nxt.gwa = f_sra;
               s_nxt.gwd = ins_val;                                // RULE3
               if (f_rec) begin
                  s_nxt.cr0 = cr_of(ins_val, s_r.xer[risx_pkg::XER_SO]); // RULE4
               end
            end else if (is_call) begin
               s_nxt.sav0 = nia;                                    // RULE6
               s_nxt.sav1 = s_r.mst[31:0] & risx_pkg::SAV1_KEEP;   // RULE7 RULE8 RULE10
               s_nxt.ev[risx_pkg::EV_CALL] = 1'b1;                  // RULE6 RULE9
            end else if (is_scv) begin
               s_nxt.lr  = nia;                                     // RULE13
               s_nxt.ctr = s_r.mst & risx_pkg::CTR_KEEP;            // RULE14 RULE15
               s_nxt.ev[risx_pkg::EV_CALL] = 1'b1;                  // RULE13
            end else if (is_subi) begin
               s_nxt.gwe = 1'b1;
               s_nxt.gwa = f_tgt;
               s_nxt.gwd = sum[31:0];                               // RULE16
               s_nxt.xer[risx_pkg::XER_CA] = sum[32];               // RULE18
            end else begin
               s_nxt.ev[risx_pkg::EV_ILL] = 1'b1;
            end
         end
         risx_pkg::ST_WB: begin
            s_nxt.ack = 1'b1;
            s_nxt.dat = g.rd_a;
            s_nxt.st  = risx_pkg::ST_IDLE;
         end
         default: begin
            s_nxt.st = risx_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r    <= '0;
         s_r.st <= risx_pkg::ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   risx_irq #(.N(risx_pkg::NEV)) u_irq (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ev_i      (s_r.ev),
      .clr_we_i  (req && we_i && sel_i == 4'hF && adr_i == risx_pkg::A_STAT && s_r.st == risx_pkg::ST_IDLE),
      .clr_i     (dat_i[risx_pkg::NEV-1:0]),
      .mask_we_i (req && we_i && sel_i == 4'hF && adr_i == risx_pkg::A_MASK && s_r.st == risx_pkg::ST_IDLE),
      .mask_i    (dat_i[risx_pkg::NEV-1:0]),
      .stat_o    (stat_w),
      .mask_o    (mask_w),
      .irq_o     (irq_w)
   );

   assign dat_o  = s_r.dat;
   assign ack_o  = s_r.ack;
   assign err_o  = s_r.err;
   assign busy_o = s_r.busy;
   assign irq_o  = irq_w;
endmodule
`default_nettype wire

// ### test/risx_exec_chk.sv
// Bus timing checker for the instruction executor ports
`timescale 1ns/1ps
`default_nettype none
module risx_exec_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        err_o,
   input wire logic        busy_o,
   input wire logic        irq_o
);
   logic cyc_q;
   logic fresh;
   // New request seen by an idle block
   always_ff @(posedge clk_i) begin
      cyc_q <= cyc_i;
   end
   assign fresh = cyc_i && stb_i && !cyc_q && !busy_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_exec;
      ack_o && busy_o ##1 busy_o && !ack_o ##1 !busy_o;
   endsequence
   sequence s_late;
      !ack_o ##1 ack_o;
   endsequence
   chk_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   chk_err_pulse: assert property (err_o |=> !err_o)
      else $error("err longer than one cycle");
   chk_reg_answer: assert property (fresh && !we_i && adr_i == risx_pkg::A_STAT |=> ack_o && !err_o)
      else $error("register read not answered next cycle");
   chk_gpr_answer: assert property (fresh && !we_i && adr_i >= risx_pkg::A_GPR0
      && adr_i <= risx_pkg::A_GPR_END |=> s_late)
      else $error("register file read not answered in two cycles");
   chk_bad_access: assert property (fresh && (adr_i == 8'h10 || (we_i && sel_i != 4'hF)) |=> err_o && !ack_o)
      else $error("bad access not refused");
   chk_exec_start: assert property (fresh && we_i && sel_i == 4'hF && adr_i == risx_pkg::A_INSN |=> s_exec)
      else $error("instruction execution timing wrong");
   chk_busy_quiet: assert property (busy_o && $past(busy_o) |-> !ack_o && !err_o)
      else $error("answer given while executing");
   chk_data_hold: assert property (!$past(rst_i) && !$stable(dat_o) |-> (ack_o || err_o) && !we_i)
      else $error("read data changed outside a read");
   chk_irq_cause: assert property (!$stable(irq_o) |-> ack_o || $past(busy_o, 2))
      else $error("interrupt changed without an event or a register write");
endmodule
bind risx_exec risx_exec_chk u_risx_exec_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .err_o(err_o), .busy_o(busy_o), .irq_o(irq_o));
`default_nettype wire

// ### test/risx_host.sv
// Wishbone master standing in for the instruction issue side
`timescale 1ns/1ps
`default_nettype none
module risx_host (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic        err_i,
   input  wire logic [31:0] dat_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic      [7:0]  adr_o,
   output logic      [3:0]  sel_o,
   output logic      [31:0] dat_o
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   // Result code: 0 ack, 1 err, 2 no answer
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
      output logic [31:0] q, output logic [1:0] r);
      int n;
      r = 2'd2;
      q = 32'h0;
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= s;
      dat_o <= d;
      for (n = 0; n < 50 && r == 2'd2; n++) begin
         @(posedge clk_i);
         if (ack_i === 1'b1) begin
            r = 2'd0;
            q = dat_i;
         end else if (err_i === 1'b1) begin
            r = 2'd1;
         end
      end
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
      dat_o <= ~d;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ### test/risx_exec_tb.sv
// Self-checking bench for the instruction executor
`timescale 1ns/1ps
`default_nettype none
module risx_exec_tb;
   localparam logic [31:0] ALL = 32'hFFFFFFFF;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc, stb, we, ack, err, busy, irq;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wd, rdat;
   int          errors = 0;
   int          checked = 0;
   initial forever #50 clk_i = ~clk_i;
   risx_host u_risx_host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
   risx_exec u_risx_exec (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack), .err_o(err), .busy_o(busy), .irq_o(irq));
   // ----
   // Bus access
   // ----
   task automatic give_verdict();
      if (errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
      output logic [31:0] q, output logic [1:0] r);
      u_risx_host.xfer(w, a, s, d, q, r);
      if (r == 2'd2) begin
         errors++;
         give_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic [1:0]  r;
      bus(1'b1, a, 4'hF, d, q, r);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      logic [1:0]  r;
      bus(1'b0, a, 4'hF, 32'h0, q, r);
      chk(q & m, e & m);
   endtask
   task automatic exec(input logic [31:0] insn);
      int n;
      wr(risx_pkg::A_INSN, insn);
      for (n = 0; n < 20; n++) begin
         @(negedge clk_i);
         if (busy === 1'b0) break;
      end
      if (busy !== 1'b0) begin
         errors++;
         give_verdict();
      end
      @(posedge clk_i);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_sub();
      wr(8'h5C, 32'hEFFFFFFF);
      exec({6'h0C, 5'd8, 5'd7, 16'h0800});
      rdc(8'h60, ALL, 32'hF00007FF);
      rdc(risx_pkg::A_XER, 32'h4, 32'h0);
      wr(8'h5C, 32'h5);
      exec({6'h0C, 5'd8, 5'd7, 16'hFFFF});
      rdc(8'h60, ALL, 32'h4);
      rdc(risx_pkg::A_XER, 32'h7, 32'h4);
      rdc(risx_pkg::A_CR0, 32'hF, 32'h0);
   endtask
   task automatic t_rot();
      logic [31:0] src [4] = '{32'hB0043000, 32'h80000000, 32'h7FFFFFFF, 32'h0};
      logic [31:0] amt [4] = '{32'h4, 32'h0, 32'h1F, 32'hFFFFFFE4};
      logic [31:0] old [4] = '{32'h0, 32'h0, 32'h1, 32'hFFFFFFFF};
      logic [31:0] ex [4] = '{32'h08000000, 32'h80000000, 32'h0, 32'hF7FFFFFF};
      logic [31:0] cr [4] = '{32'h4, 32'h8, 32'h2, 32'h2};
      for (int i = 0; i < 4; i++) begin
         wr(8'h54, src[i]);
         wr(8'h58, amt[i]);
         wr(8'h50, old[i]);
         exec({6'h1F, 5'd5, 5'd4, 5'd6, 10'h219, i < 3});
         rdc(8'h50, ALL, ex[i]);
         rdc(risx_pkg::A_CR0, 32'hF, cr[i]);
         rdc(risx_pkg::A_XER, 32'h7, 32'h4);
      end
   endtask
   task automatic t_call();
      wr(risx_pkg::A_STAT, 32'h7);
      wr(risx_pkg::A_MASK, 32'h0);
      wr(risx_pkg::A_MST_HI, 32'h12345678);
      wr(risx_pkg::A_MST_LO, 32'hA5A5A5A5);
      wr(risx_pkg::A_CIA, 32'h1000);
      exec({6'h11, 14'h0, 7'h0, 3'h0, 2'b10});
      rdc(risx_pkg::A_SAV0, ALL, 32'h1004);
      rdc(risx_pkg::A_SAV1, 32'h87C0FFFF, 32'hA5A5A5A5);
      rdc(risx_pkg::A_MST_LO, ALL, 32'hA5A5A5A5);
      rdc(risx_pkg::A_STAT, 32'h7, 32'h3);
      @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
      wr(risx_pkg::A_MASK, 32'h2);
      @(posedge clk_i);
      chk({31'h0, irq}, 32'h1);
      wr(risx_pkg::A_STAT, 32'h2);
      @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
      rdc(risx_pkg::A_STAT, 32'h7, 32'h1);
      wr(risx_pkg::A_CIA, 32'h2000);
      exec({6'h11, 14'h0, 7'h1, 3'h0, 2'b01});
      rdc(risx_pkg::A_LR, ALL, 32'h2004);
      rdc(risx_pkg::A_CTR_HI, ALL, 32'h12345678);
      rdc(risx_pkg::A_CTR_LO, 32'h87C0FFFF, 32'hA5A5A5A5);
      rdc(risx_pkg::A_MST_HI, ALL, 32'h12345678);
   endtask
   task automatic t_fault();
      logic [31:0] q;
      logic [1:0]  r;
      bus(1'b0, 8'h10, 4'hF, 32'h0, q, r);
      chk({30'h0, r}, 32'h1);
      bus(1'b1, risx_pkg::A_MASK, 4'h3, 32'h7, q, r);
      chk({30'h0, r}, 32'h1);
      rdc(risx_pkg::A_MASK, 32'h7, 32'h2);
      wr(risx_pkg::A_STAT, 32'h7);
      wr(risx_pkg::A_INSN, {6'h11, 26'h0});
      rdc(risx_pkg::A_CTRL, 32'h1, 32'h0);
      rdc(risx_pkg::A_STAT, 32'h6, 32'h4);
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_sub();
      t_rot();
      t_call();
      t_fault();
      give_verdict();
   end
endmodule
`default_nettype wire
